// ### core/jesd_cfg_check.sv
// combinational legality check of one link parameter set
`default_nettype none
module jesd_cfg_check
   import jesd_cfg_pkg::*;
(
   input wire logic [2:0] lanes,
   input wire logic [3:0] convs,
   input wire logic [4:0] octets,
   input wire logic [5:0] frames_k,
   input wire logic [1:0] ctrl_bits,
   input wire logic [4:0] word_bits,
   input wire logic [4:0] res_bits,
   input wire logic [5:0] dec_ratio,
   input wire logic [31:0] adc_rate_ksps,
   input wire logic [31:0] lane_rate_kbps,
   input wire logic [7:0] band,
   input wire logic full_bw,
   output logic legal
);
   logic k_ok, fmt_ok, rate_ok, band_ok, fb_ok, pack_ok, dec_ok, per_lane_ok;
   logic [5:0] kmin;
   logic [63:0] lhs, rhs;
   logic [1:0] band_idx;
   logic [11:0] bits_x5, per_lane_x4, band_ratio_x4;

   // decimation ratios allowed at a lane-to-sample ratio (times four) in the lowest band
   function automatic logic dec_listed(input logic [11:0] q4, input logic [5:0] d);
      case (q4)
         12'd20: return d == 6'd1;
         12'd40: return d == 6'd1 || d == 6'd2 || d == 6'd3;
         12'd60: return d == 6'd3;
         12'd80: return d == 6'd2 || d == 6'd4 || d == 6'd5 || d == 6'd6;
         12'd120: return d == 6'd3 || d == 6'd6;
         12'd160: return d == 6'd4 || d == 6'd8 || d == 6'd10 || d == 6'd12;
         12'd240: return d == 6'd6 || d == 6'd12;
         12'd320: return d == 6'd8 || d == 6'd16 || d == 6'd20 || d == 6'd24;
         12'd640: return d == 6'd16 || d == 6'd40 || d == 6'd48;
         default: return 1'b0;
      endcase
   endfunction
   always_comb begin
      case (octets)
         5'd1: kmin = 6'd20;
         5'd2: kmin = 6'd12;
         5'd4: kmin = 6'd8;
         5'd8, 5'd16: kmin = 6'd4;
         default: kmin = 6'd63;
      endcase
   end
   // multiframe length legal for the octet count
   assign k_ok = (frames_k >= kmin) && (frames_k <= K_MAX) && (frames_k[1:0] == 2'b00);
   always_comb begin
      case (word_bits)
         NP12: fmt_ok = res_bits >= 5'd8 && res_bits <= NP12 && lanes >= 3'd1 && lanes <= 3'd4
               && (convs == 4'd1 || convs == 4'd2 || convs == 4'd4 || convs == 4'd8);
         NP8: fmt_ok = res_bits >= 5'd7 && res_bits <= NP8 && ctrl_bits <= 2'd1
               && (convs == 4'd1 || convs == 4'd2) && lanes >= 3'd1 && lanes <= 3'd4;
         NP16: fmt_ok = res_bits >= 5'd8 && res_bits <= NP16 && lanes >= 3'd1 && lanes <= 3'd4;
         default: fmt_ok = 1'b0;
      endcase
   end
   // octets per frame and converter count must both be nonzero
   assign pack_ok = (octets != 5'd0) && (convs != 4'd0);
   // lane rate = M*N'*10/8*fout/L with fout = adc/decimation, checked exactly
   assign lhs = 64'(lane_rate_kbps) * 64'(lanes) * 64'(dec_ratio) * 64'(LRATE_DEN);
   assign rhs = 64'(convs) * 64'(word_bits) * 64'(LRATE_NUM) * 64'(adc_rate_ksps);
   // lcm limit reduced to a bound on the decimation ratio itself
   assign rate_ok = (lhs == rhs) && dec_ratio != 6'd0 && 7'(dec_ratio) <= LCM_MAX;
   always_comb begin
      if (lane_rate_kbps > LRATE_B3_KBPS) band_idx = 2'd3;
      else if (lane_rate_kbps >= LRATE_B2_KBPS) band_idx = 2'd2;
      else if (lane_rate_kbps >= LRATE_B1_KBPS) band_idx = 2'd1;
      else band_idx = 2'd0;
   end
   always_comb begin
      case (band_idx)
         2'd3: band_ok = band == BAND_13G5_16G;
         2'd2: band_ok = band == BAND_6G75_13G5;
         2'd1: band_ok = band == BAND_3G375_6G75;
         default: band_ok = band == BAND_1G6875_3G375;
      endcase
   end
   // four times the lane-to-sample ratio: M*N'*5/L, must come out whole
   assign bits_x5 = 12'(convs) * 12'(word_bits) * 12'd5;
   always_comb begin
      per_lane_ok = 1'b1;
      case (lanes)
         3'd1: per_lane_x4 = bits_x5;
         3'd2: begin
            per_lane_x4 = bits_x5 >> 1;
            per_lane_ok = !bits_x5[0];
         end
         3'd3: begin
            per_lane_x4 = bits_x5 / 12'd3;
            per_lane_ok = (per_lane_x4 * 12'd3) == bits_x5;
         end
         3'd4: begin
            per_lane_x4 = bits_x5 >> 2;
            per_lane_ok = bits_x5[1:0] == 2'b00;
         end
         default: begin
            per_lane_x4 = 12'h000;
            per_lane_ok = 1'b0;
         end
      endcase
   end
   // each band up halves the ratio that the internal dividers see
   always_comb begin
      band_ratio_x4 = per_lane_x4 >> band_idx;
      dec_ok = per_lane_ok && ((band_ratio_x4 << band_idx) == per_lane_x4)
         && dec_listed(band_ratio_x4, dec_ratio);
   end
   // full bandwidth: N'=16, N=14, L=4, M=1, F=1, CS=0, K=32, no decimation
   assign fb_ok = !full_bw || (word_bits == NP16 && 6'(res_bits) == N_FULL && lanes == 3'd4
      && convs == 4'd1 && octets == 5'd1 && ctrl_bits == 2'd0 && frames_k == K_MAX
      && dec_ratio == 6'd1);
   // full bandwidth carries its own fixed set in place of the ratio list
   assign legal = k_ok && fmt_ok && pack_ok && rate_ok && band_ok && fb_ok
      && (dec_ok || full_bw)
      && lane_rate_kbps >= LRATE_MIN_KBPS && lane_rate_kbps <= LRATE_MAX_KBPS
      && 64'(lane_rate_kbps) <= 64'(RATE_DIV) * 64'(adc_rate_ksps);
endmodule : jesd_cfg_check
`default_nettype wire

// ### core/jesd_cfg_pkg.sv
// constants for the transmit link configuration checker
`default_nettype none
package jesd_cfg_pkg;
   localparam logic [11:0] ADDR_LINK0 = 12'h000;
   localparam logic [11:0] ADDR_LINK1 = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_RATE_LO = 12'h00c;
   localparam logic [11:0] ADDR_BAND_IDX = 12'h56e;
   localparam logic [13:0] ADDR_BAND = {ADDR_BAND_IDX, 2'b00};
   localparam logic [7:0] BAND_13G5_16G = 8'h30;
   localparam logic [7:0] BAND_6G75_13G5 = 8'h00;
   localparam logic [7:0] BAND_3G375_6G75 = 8'h10;
   localparam logic [7:0] BAND_1G6875_3G375 = 8'h50;
   localparam logic [7:0] BAND_RESET = 8'h10;
   // lane rate limits in kbps, 32 bit
   localparam logic [31:0] LRATE_MIN_KBPS = 32'd1687500;
   localparam logic [31:0] LRATE_MAX_KBPS = 32'd16000000;
   localparam logic [31:0] LRATE_B1_KBPS = 32'd3375000;
   localparam logic [31:0] LRATE_B2_KBPS = 32'd6750000;
   localparam logic [31:0] LRATE_B3_KBPS = 32'd13500000;
   localparam logic [5:0] K_MAX = 6'd32;
   localparam logic [6:0] LCM_MAX = 7'd64;
   localparam logic [5:0] N_FULL = 6'd14;
   localparam logic [4:0] NP16 = 5'd16;
   localparam logic [4:0] NP12 = 5'd12;
   localparam logic [4:0] NP8 = 5'd8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int LRATE_NUM = 10;
   localparam int LRATE_DEN = 8;
   localparam int RATE_DIV = 40;
   localparam int BASE_RATE = 20;
endpackage : jesd_cfg_pkg
`default_nettype wire

// ### core/jesd_cfg_regs.sv
// axi4-lite register file and link enable for the transmit link configuration
//
// Operation
// - K*F divisible by 4, K<=32, minimum K (the check requires K itself to be divisible by 4)
// - only listed decimation ratios accepted
// - fout equals sample rate over decimation
// - M, L, F, S describe frame packing
// - multiframe spans K frames
// - 12-bit word: N 8-12, CS 0-3
// - 8-bit word: N 7-8, CS 0-1, M<=2
// - CS sets control bits in tail
// - full bandwidth fixed link parameters
// - lane rate from M, N', L, fout
// - 14-bit sample split into two octets
// - control bits inserted MSB first
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
module jesd_cfg_regs
   import jesd_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] adc_rate_ksps,
   input wire logic [13:0] sample_in,
   input wire logic [2:0] ctrl_in,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic link_enable,
   output logic cfg_invalid,
   output logic [7:0] octet_hi,
   output logic [7:0] octet_lo
);
   logic [31:0] link0_r, link1_r, rate_r;
   logic [7:0] band_r;
   logic [15:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_have_r, w_have_r;
   logic legal, link_en_r, invalid_r;
   logic [7:0] octet_hi_r, octet_lo_r;
   logic [2:0] tail_mask;
   logic wr_fire;

   // byte-lane merge used by the link0, link1 and rate registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [15:0] a);
      return a == 16'(ADDR_LINK0) || a == 16'(ADDR_LINK1) || a == 16'(ADDR_STATUS)
         || a == 16'(ADDR_RATE_LO) || a == 16'(ADDR_BAND);
   endfunction

   // write channel capture, address and data in any order
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 16'h0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // link0: L[2:0] M[7:4] F[12:8] K[21:16] CS[25:24]; link1: N'[4:0] N[12:8] decim[21:16]
   // full bandwidth [24]; rate register holds the lane rate in kbps
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link0_r <= 32'h0000_0000;
         link1_r <= 32'h0000_0000;
         rate_r <= 32'h0000_0000;
         band_r <= BAND_RESET;
      end else if (ce && wr_fire) begin
         case (awaddr_r)
            16'(ADDR_LINK0): link0_r <= merge(link0_r, wdata_r, wstrb_r);
            16'(ADDR_LINK1): link1_r <= merge(link1_r, wdata_r, wstrb_r);
            16'(ADDR_RATE_LO): rate_r <= merge(rate_r, wdata_r, wstrb_r);
            16'(ADDR_BAND): if (wstrb_r[0]) band_r <= wdata_r[7:0];
            default: ;
         endcase
      end
   end

   jesd_cfg_check u_check (
      .lanes(link0_r[2:0]),
      .convs(link0_r[7:4]),
      .octets(link0_r[12:8]),
      .frames_k(link0_r[21:16]),
      .ctrl_bits(link0_r[25:24]),
      .word_bits(link1_r[4:0]),
      .res_bits(link1_r[12:8]),
      .dec_ratio(link1_r[21:16]),
      .adc_rate_ksps(adc_rate_ksps),
      .lane_rate_kbps(rate_r),
      .band(band_r),
      .full_bw(link1_r[24]),
      .legal(legal)
   );

   // link runs only while the programmed set is legal
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_en_r <= 1'b0;
         invalid_r <= 1'b1;
      end else if (ce) begin
         link_en_r <= legal;
         invalid_r <= !legal;
      end
   end
   assign link_enable = link_en_r;
   assign cfg_invalid = invalid_r;

   // tail positions replaced by control bits, msb first
   always_comb begin
      case (link0_r[25:24])
         2'd1: tail_mask = 3'b100;
         2'd2: tail_mask = 3'b110;
         2'd3: tail_mask = 3'b111;
         default: tail_mask = 3'b000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         octet_hi_r <= 8'h00;
         octet_lo_r <= 8'h00;
      end else if (ce) begin
         octet_hi_r <= link_en_r ? sample_in[13:6] : 8'h00;
         octet_lo_r <= link_en_r ? {sample_in[5:0], (ctrl_in[2:1] & tail_mask[2:1])} : 8'h00;
      end
   end
   assign octet_hi = octet_hi_r;
   assign octet_lo = octet_lo_r;

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
               16'(ADDR_LINK0): s_axi_rdata <= link0_r;
               16'(ADDR_LINK1): s_axi_rdata <= link1_r;
               16'(ADDR_STATUS): s_axi_rdata <= {30'h0000_0000, invalid_r, link_en_r};
               16'(ADDR_RATE_LO): s_axi_rdata <= rate_r;
               16'(ADDR_BAND): s_axi_rdata <= {24'h00_0000, band_r};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   property p_enable_follows_legal;
      @(posedge aclk) disable iff (!aresetn)
      (ce && legal) |=> link_enable && !cfg_invalid;
   endproperty
   a_enable_follows_legal: assert property (p_enable_follows_legal) else $error("enable lost");

   property p_illegal_holds_off;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !legal) |=> !link_enable && cfg_invalid;
   endproperty
   a_illegal_holds_off: assert property (p_illegal_holds_off) else $error("link not held off");

   property p_hi_octet;
      @(posedge aclk) disable iff (!aresetn)
      (ce && link_enable) |=> octet_hi == $past(sample_in[13:6]);
   endproperty
   a_hi_octet: assert property (p_hi_octet) else $error("high octet wrong");

   property p_cs_zero_tail;
      @(posedge aclk) disable iff (!aresetn)
      (ce && link_enable && link0_r[25:24] == 2'd0) |=> octet_lo[1:0] == 2'b00;
   endproperty
   a_cs_zero_tail: assert property (p_cs_zero_tail) else $error("tail not zero");

   property p_cs_one;
      @(posedge aclk) disable iff (!aresetn)
      (ce && link_enable && link0_r[25:24] == 2'd1) |=> octet_lo[0] == 1'b0
         && octet_lo[1] == $past(ctrl_in[2]);
   endproperty
   a_cs_one: assert property (p_cs_one) else $error("control bit order wrong");

   property p_bresp_after_write;
      @(posedge aclk) disable iff (!aresetn)
      (ce && wr_fire) |=> s_axi_bvalid;
   endproperty
   a_bresp_after_write: assert property (p_bresp_after_write) else $error("no write response");

   property p_band_rule;
      @(posedge aclk) disable iff (!aresetn)
      (rate_r > LRATE_B3_KBPS && band_r != BAND_13G5_16G) |-> !legal;
   endproperty
   a_band_rule: assert property (p_band_rule) else $error("band mismatch accepted");

   property p_rate_range;
      @(posedge aclk) disable iff (!aresetn)
      (rate_r < LRATE_MIN_KBPS || rate_r > LRATE_MAX_KBPS) |-> !legal;
   endproperty
   a_rate_range: assert property (p_rate_range) else $error("rate out of range accepted");

   property p_k_limit;
      @(posedge aclk) disable iff (!aresetn)
      (link0_r[21:16] > K_MAX || link0_r[17:16] != 2'b00) |-> !legal;
   endproperty
   a_k_limit: assert property (p_k_limit) else $error("bad multiframe accepted");
endmodule : jesd_cfg_regs
`default_nettype wire

// ### dv/jesd204b_tx_link_config_tb.sv
// self-checking bench for the link configuration register block
`default_nettype none
module jesd204b_tx_link_config_tb import jesd_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic link_enable, cfg_invalid;
   logic [31:0] adc = 0, wdata = 0, rdata, rnd = 32'h68ea5e89;
   logic [13:0] smp = 0;
   logic [2:0] ctl = 0;
   logic [3:0] wstrb = 4'hf;
   logic [15:0] awaddr = 0, araddr = 0, rx_word;
   logic [1:0] bresp, rresp;
   logic [7:0] o_hi, o_lo;
   int bad_count = 0, checked = 0;
   jesd_cfg_regs jesd_cfg_regs_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .adc_rate_ksps(adc), .sample_in(smp), .ctrl_in(ctl), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link_enable(link_enable), .cfg_invalid(cfg_invalid),
      .octet_hi(o_hi), .octet_lo(o_lo));
   link_rx_model link_rx_model_inst (.aclk(aclk), .link_enable(link_enable),
      .octet_hi(o_hi), .octet_lo(o_lo), .rx_word(rx_word));
   initial begin
      forever #20 aclk = ~aclk;
   end
   task automatic close_out;
      $display("counts checked=%0d bad=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic tmo;
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      close_out;
   endtask
   task automatic cmpv(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmpr(input logic [1:0] g, input logic [1:0] e);
      cmpv({30'h0, g}, {30'h0, e});
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] band_of(input logic [31:0] r);
      if (r > LRATE_B3_KBPS) return BAND_13G5_16G;
      if (r >= LRATE_B2_KBPS) return BAND_6G75_13G5;
      if (r >= LRATE_B1_KBPS) return BAND_3G375_6G75;
      return BAND_1G6875_3G375;
   endfunction
   function automatic logic [7:0] lo_of(input logic [13:0] s, input logic [2:0] c, input int cs);
      logic [1:0] t;
      t = (cs == 0) ? 2'b00 : (cs == 1) ? {c[2], 1'b0} : c[2:1];
      return {s[5:0], t};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) break;
      end
      if (n == 40) tmo;
      bready <= 0;
      cmpr(bresp, er);
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) break;
      end
      if (n == 40) tmo;
      rready <= 0;
      d = rdata;
      r = rresp;
   endtask
   task automatic pk(input int cs, input logic en);
      logic [13:0] s;
      logic [2:0] c;
      rnd = lfsr(rnd);
      s = rnd[13:0];
      c = rnd[18:16];
      @(posedge aclk);
      smp <= s;
      ctl <= c;
      @(posedge aclk);
      #1;
      cmpv(o_hi, en ? s[13:6] : 8'h00);
      cmpv(o_lo, en ? lo_of(s, c, cs) : 8'h00);
      @(posedge aclk);
      #1;
      if (en) cmpv(rx_word[15:2], s);
   endtask
   task automatic cfg(input int l, m, f, k, cs, np, n, dr, a, fb, bb, input logic en);
      logic [31:0] r;
      logic [31:0] d;
      logic [1:0] e;
      r = 32'(longint'(m) * np * 10 / 8 * a / (dr * l));
      @(posedge aclk);
      adc <= a;
      wr({4'h0, ADDR_LINK0}, {6'h00, cs[1:0], 2'b00, k[5:0], 3'b000, f[4:0], m[3:0], 1'b0,
         l[2:0]}, RESP_OKAY);
      wr({4'h0, ADDR_LINK1}, {7'h00, fb[0], 2'b00, dr[5:0], 3'b000, n[4:0], 3'b000,
         np[4:0]}, RESP_OKAY);
      wr({4'h0, ADDR_RATE_LO}, r, RESP_OKAY);
      wr({2'b00, ADDR_BAND}, {24'h0, band_of(r) ^ (bb ? 8'h40 : 8'h00)}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      cmpv(link_enable, en);
      cmpv(cfg_invalid, !en);
      rd({4'h0, ADDR_STATUS}, d, e);
      cmpv(d, {30'h0, !en, en});
      pk(cs, en);
      $display("test cfg l=%0d m=%0d f=%0d k=%0d dec=%0d done", l, m, f, k, dr);
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      tmo;
   end
   initial begin
      logic [31:0] d;
      logic [1:0] e;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rd({2'b00, ADDR_BAND}, d, e);
      cmpv(d[7:0], BAND_RESET);
      rd({4'h0, ADDR_STATUS}, d, e);
      cmpv(d[1:0], 2'b10);
      rd(16'h0100, d, e);
      cmpr(e, RESP_SLVERR);
      cmpv(d, 32'h0);
      wr(16'h0100, 32'h5a, RESP_SLVERR);
      wr({4'h0, ADDR_LINK0}, 32'hffff_ffff, RESP_OKAY);
      wstrb <= 4'h1;
      wr({4'h0, ADDR_LINK0}, 32'h0000_0000, RESP_OKAY);
      wstrb <= 4'hf;
      rd({4'h0, ADDR_LINK0}, d, e);
      cmpv(d, 32'hffff_ff00);
      $display("test reset and unmapped done");
      cfg(4, 4, 4, 32, 0, 16, 14, 1, 600000, 0, 0, 1);
      cfg(4, 4, 4, 32, 0, 16, 14, 1, 600000, 0, 1, 0);
      cfg(4, 4, 4, 32, 0, 16, 14, 1, 700000, 0, 1, 0);
      cfg(4, 4, 4, 36, 0, 16, 14, 1, 600000, 0, 0, 0);
      cfg(4, 4, 4, 4, 0, 16, 14, 1, 600000, 0, 0, 0);
      cfg(4, 4, 4, 8, 0, 16, 14, 1, 600000, 0, 0, 1);
      cfg(4, 4, 4, 32, 0, 16, 14, 2, 1200000, 0, 0, 0);
      cfg(4, 4, 4, 32, 0, 16, 14, 2, 600000, 0, 0, 1);
      cfg(4, 4, 4, 32, 0, 16, 14, 1, 1400000, 0, 0, 0);
      cfg(4, 1, 1, 32, 0, 16, 14, 1, 1300000, 1, 0, 1);
      cfg(4, 4, 4, 32, 0, 8, 8, 1, 600000, 0, 0, 0);
      cfg(4, 4, 3, 32, 0, 12, 13, 1, 600000, 0, 0, 0);
      for (int cs = 0; cs < 4; cs++) begin
         cfg(4, 4, 4, 32, cs, 16, 14, 1, 600000, 0, 0, 1);
         repeat (8) pk(cs, 1);
      end
      d = {16'h0000, o_hi, o_lo};
      @(posedge aclk);
      ce <= 0;
      smp <= ~smp;
      repeat (3) @(posedge aclk);
      #1;
      cmpv({16'h0000, o_hi, o_lo}, d);
      cmpv(link_enable, 1'b1);
      @(posedge aclk);
      ce <= 1;
      $display("test clock enable freeze done");
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      #1;
      cmpv(link_enable, 1'b0);
      cmpv(cfg_invalid, 1'b1);
      rd({2'b00, ADDR_BAND}, d, e);
      cmpv(d[7:0], BAND_RESET);
      $display("test second reset done");
      close_out;
   end
endmodule // jesd204b_tx_link_config_tb
`default_nettype wire

// ### dv/link_rx_model.sv
// far-side lane receiver model: rebuilds sample words from the two lane octets
`default_nettype none
module link_rx_model (
   input wire logic aclk,
   input wire logic link_enable,
   input wire logic [7:0] octet_hi,
   input wire logic [7:0] octet_lo,
   output logic [15:0] rx_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // no valid data while the link is off, so the word is inverted every clock
   always_ff @(posedge aclk) begin
      if (link_enable) begin
         rx_word <= {octet_hi, octet_lo};
      end else begin
         rx_word <= ~rx_word;
      end
   end
endmodule // link_rx_model
`default_nettype wire
